// file: hdl/stp_pkg.sv
package stp_pkg;
   // ******************************
   // register byte offsets
   // ******************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_VCODE = 8'h08;
   localparam logic [7:0] OFS_PIN_MODE = 8'h0C;
   localparam logic [7:0] OFS_PIN_OUT = 8'h10;
   localparam logic [7:0] OFS_WATCHDOG_LOAD = 8'h14;
   localparam logic [7:0] OFS_INT_STATUS = 8'h18;
   localparam logic [7:0] OFS_INT_MASK = 8'h1C;

   // ******************************
   // control fields
   // ******************************
   localparam int CTRL_RST_TRIG = 0;
   localparam int CTRL_PWR_BTN = 1;
   localparam int CTRL_WATCHDOG_EN = 2;
   localparam int CTRL_MGMT_MODE = 3;
   localparam int CTRL_FAN6 = 4;
   localparam int CTRL_FAN7 = 5;
   localparam int CTRL_FAN_STRAP = 6;
   localparam logic [8:0] CTRL_RESET = 9'h030;

   // ******************************
   // status and interrupt fields
   // ******************************
   localparam int ST_TABLE9 = 0;
   localparam int ST_ADDR0 = 1;
   localparam int ST_ADDR1 = 2;
   localparam int ST_TRIP = 3;
   localparam int ST_RST_ACTIVE = 4;
   localparam int ST_PWR_GOOD = 5;
   localparam int EV_TRIP_A = 0;
   localparam int EV_TRIP_B = 1;
   localparam int EV_CHASSIS = 2;
   localparam int EV_WATCHDOG = 3;
   localparam int EV_OVERTEMP = 4;
   localparam int EV_COUNT = 5;
   localparam int VCODE_W = 6;
   localparam logic [15:0] WATCHDOG_LOAD_RESET = 16'h03E8;

   // ******************************
   // timing
   // ******************************
   localparam int CLK_HZ = 50_000_000;
   localparam int RESET_PULSE_MS = 100;
   localparam int WATCHDOG_TICK_MS = 1;
   localparam int RESET_PULSE_CYCLES = RESET_PULSE_MS * (CLK_HZ / 1000);
   localparam int WATCHDOG_TICK_CYCLES = WATCHDOG_TICK_MS * (CLK_HZ / 1000);
endpackage

// file: hdl/stp_pulse_timer.sv
module stp_pulse_timer #(
   parameter int COUNT = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // control
   input wire logic start_in,
   output logic active_out
);
   logic [31:0] remain;

   // a start while active is ignored, so the pulse never stretches
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         active_out <= 1'b0;
         remain <= 32'h0;
      end else if (active_out) begin
         if (remain == 32'h0) begin
            active_out <= 1'b0;
         end else begin
            remain <= remain - 32'h1;
         end
      end else if (start_in) begin
         active_out <= 1'b1;
         remain <= 32'(COUNT - 1);
      end
   end
endmodule

// file: hdl/stp_top.sv
module stp_top #(
   parameter int PULSE_CYCLES = stp_pkg::RESET_PULSE_CYCLES,
   parameter int TICK_CYCLES = stp_pkg::WATCHDOG_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // straps, shared with fan outputs: [0]=addr bit0, [1]=addr bit1, [2]=table
   input wire logic addr_strap_bit0_in,
   input wire logic addr_strap_bit1_in,
   input wire logic regulator_table_strap_in,
   output logic [2:0] fan_strap_out,
   output logic [2:0] fan_strap_oe_out,
   output logic fan_pwm_sixth_out,
   output logic fan_pwm_seventh_out,
   // power and thermal
   input wire logic main_power_good_in,
   input wire logic cpu_a_trip_n_in,
   input wire logic cpu_b_trip_n_in,
   input wire logic [2:0] sensor_overtemp_in,
   input wire logic chassis_intrusion_in,
   output logic regulator_enable_out,
   output logic regulator_enable_oe_out,
   output logic overtemp_shutdown_n_out,
   output logic overtemp_shutdown_n_oe_out,
   // system reset and power button
   input wire logic system_reset_in_n,
   output logic system_reset_n_out,
   output logic system_reset_n_oe_out,
   output logic power_button_out_n,
   output logic power_button_oe_out,
   // voltage code / general io pins: [5:0] cpu a, [11:6] cpu b
   input wire logic [11:0] vcode_in,
   output logic [11:0] vcode_out,
   output logic [11:0] vcode_oe_out,
   // interrupts
   output logic irq_out,
   output logic mgmt_interrupt_n_out,
   output logic mgmt_interrupt_n_oe_out
);
   // ******************************
   // state
   // ******************************
   logic aw_got, w_got, wr_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [8:0] ctrl;
   logic [11:0] pin_mode, pin_out;
   logic [15:0] watchdog_load, watchdog_count;
   logic [4:0] int_status, int_mask, events;
   logic strap_done, table9, addr0, addr1;
   logic trip_latched, trip_now;
   logic [11:0] vcode_q;
   logic [31:0] tick_div;
   logic watchdog_tick, watchdog_expire, rst_start, rst_active;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= stp_pkg::OFS_INT_MASK;
   endfunction

   // ******************************
   // axi4-lite write channel
   // ******************************
   assign aw_got = !s_axi_awready_out;
   assign w_got = !s_axi_wready_out;
   assign wr_fire = aw_got && w_got && !s_axi_bvalid_out;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= 2'h0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0;
         wr_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            s_axi_awready_out <= 1'b0;
            wr_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            s_axi_wready_out <= 1'b0;
            wr_data <= s_axi_wdata_in;
            wr_strb <= s_axi_wstrb_in;
         end
         if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= mapped(wr_addr) ? 2'h0 : 2'h2;
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // ******************************
   // axi4-lite read channel
   // ******************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0;
         s_axi_rresp_out <= 2'h0;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out <= mapped(s_axi_araddr_in) ? 2'h0 : 2'h2;
         unique case (s_axi_araddr_in)
            stp_pkg::OFS_CTRL: s_axi_rdata_out <= {23'h0, ctrl};
            stp_pkg::OFS_STATUS: s_axi_rdata_out <= {26'h0, main_power_good_in, rst_active,
                                                    trip_latched, addr1, addr0, table9};
            stp_pkg::OFS_VCODE: s_axi_rdata_out <= {18'h0, vcode_q[11:6], 2'h0, vcode_q[5:0]};
            stp_pkg::OFS_PIN_MODE: s_axi_rdata_out <= {20'h0, pin_mode};
            stp_pkg::OFS_PIN_OUT: s_axi_rdata_out <= {20'h0, pin_out};
            stp_pkg::OFS_WATCHDOG_LOAD: s_axi_rdata_out <= {16'h0, watchdog_load};
            stp_pkg::OFS_INT_STATUS: s_axi_rdata_out <= {27'h0, int_status};
            stp_pkg::OFS_INT_MASK: s_axi_rdata_out <= {27'h0, int_mask};
            default: s_axi_rdata_out <= 32'h0;
         endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

   // ******************************
   // software registers
   // ******************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl <= stp_pkg::CTRL_RESET;
         pin_mode <= 12'h000;
         pin_out <= 12'h000;
         watchdog_load <= stp_pkg::WATCHDOG_LOAD_RESET;
         int_mask <= 5'h00;
      end else begin
         ctrl[stp_pkg::CTRL_RST_TRIG] <= 1'b0;
         if (wr_fire) begin
            unique case (wr_addr)
               stp_pkg::OFS_CTRL: ctrl <= 9'(merge({23'h0, ctrl}, wr_data, wr_strb));
               stp_pkg::OFS_PIN_MODE: pin_mode <= 12'(merge({20'h0, pin_mode}, wr_data,
                                                            wr_strb));
               stp_pkg::OFS_PIN_OUT: pin_out <= 12'(merge({20'h0, pin_out}, wr_data,
                                                          wr_strb));
               stp_pkg::OFS_WATCHDOG_LOAD: watchdog_load <= 16'(merge({16'h0, watchdog_load},
                                                                      wr_data, wr_strb));
               stp_pkg::OFS_INT_MASK: int_mask <= 5'(merge({27'h0, int_mask}, wr_data,
                                                           wr_strb));
               default: ;
            endcase
         end
      end
   end

   // ******************************
   // straps and voltage codes
   // ******************************
   // straps caught on the first edge after reset release, never under reset
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         strap_done <= 1'b0;
         table9 <= 1'b0;
         addr0 <= 1'b0;
         addr1 <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         table9 <= regulator_table_strap_in;
         addr0 <= addr_strap_bit0_in;
         addr1 <= addr_strap_bit1_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         vcode_q <= 12'h000;
      end else begin
         vcode_q <= vcode_in;
         if (table9) begin
            vcode_q[5] <= 1'b0;
            vcode_q[11] <= 1'b0;
         end
      end
   end

   // open drain: a driven pin only ever pulls low
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         vcode_out <= 12'h000;
         vcode_oe_out <= 12'h000;
      end else begin
         vcode_out <= 12'h000;
         vcode_oe_out <= pin_mode & ~pin_out;
      end
   end

   // ******************************
   // fan output levels
   // ******************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         fan_strap_out <= 3'h0;
         fan_strap_oe_out <= 3'h0;
         fan_pwm_sixth_out <= 1'b1;
         fan_pwm_seventh_out <= 1'b1;
      end else begin
         fan_strap_oe_out <= {3{strap_done}};
         fan_strap_out <= main_power_good_in ? ctrl[stp_pkg::CTRL_FAN_STRAP +: 3] : 3'h0;
         fan_pwm_sixth_out <= ctrl[stp_pkg::CTRL_FAN6];
         fan_pwm_seventh_out <= ctrl[stp_pkg::CTRL_FAN7];
      end
   end

   // ******************************
   // thermal trip, overtemp and power button
   // ******************************
   assign trip_now = main_power_good_in && (!cpu_a_trip_n_in || !cpu_b_trip_n_in);

   // only a chip reset releases the trip, so cpu power stays removed
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         trip_latched <= 1'b0;
         regulator_enable_out <= 1'b0;
         regulator_enable_oe_out <= 1'b0;
      end else begin
         trip_latched <= trip_latched || trip_now;
         regulator_enable_oe_out <= trip_latched;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         overtemp_shutdown_n_out <= 1'b0;
         overtemp_shutdown_n_oe_out <= 1'b0;
         power_button_out_n <= 1'b0;
         power_button_oe_out <= 1'b0;
      end else begin
         overtemp_shutdown_n_oe_out <= |sensor_overtemp_in;
         power_button_oe_out <= ctrl[stp_pkg::CTRL_PWR_BTN];
      end
   end

   // ******************************
   // watchdog and system reset pulse
   // ******************************
   assign watchdog_tick = tick_div == 32'(TICK_CYCLES - 1);
   assign watchdog_expire = watchdog_tick && ctrl[stp_pkg::CTRL_WATCHDOG_EN]
                            && system_reset_in_n && watchdog_count == 16'h0001;
   assign rst_start = ctrl[stp_pkg::CTRL_RST_TRIG] || watchdog_expire;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || watchdog_tick) begin
         tick_div <= 32'h0;
      end else begin
         tick_div <= tick_div + 32'h1;
      end
   end

   // board reset low holds the watchdog reloaded
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         watchdog_count <= stp_pkg::WATCHDOG_LOAD_RESET;
      end else if (!system_reset_in_n || !ctrl[stp_pkg::CTRL_WATCHDOG_EN]
                   || watchdog_expire) begin
         watchdog_count <= watchdog_load;
      end else if (watchdog_tick && watchdog_count != 16'h0000) begin
         watchdog_count <= watchdog_count - 16'h0001;
      end
   end

   stp_pulse_timer #(
      .COUNT(PULSE_CYCLES)
   ) u_pulse (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .start_in(rst_start),
      .active_out(rst_active)
   );

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         system_reset_n_out <= 1'b0;
         system_reset_n_oe_out <= 1'b0;
      end else begin
         system_reset_n_oe_out <= rst_active;
      end
   end

   // ******************************
   // interrupts
   // ******************************
   assign events = {|sensor_overtemp_in, watchdog_expire, chassis_intrusion_in,
                    main_power_good_in && !cpu_b_trip_n_in,
                    main_power_good_in && !cpu_a_trip_n_in};

   // a new event in the clearing cycle wins over the clear
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         int_status <= 5'h00;
      end else if (wr_fire && wr_addr == stp_pkg::OFS_INT_STATUS) begin
         int_status <= (int_status & ~(wr_data[4:0] & {5{wr_strb[0]}})) | events;
      end else begin
         int_status <= int_status | events;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
         mgmt_interrupt_n_out <= 1'b0;
         mgmt_interrupt_n_oe_out <= 1'b1;
      end else begin
         irq_out <= |(int_status & int_mask);
         mgmt_interrupt_n_out <= ctrl[stp_pkg::CTRL_MGMT_MODE] ? 1'b0
                                 : |(int_status & int_mask);
         mgmt_interrupt_n_oe_out <= ctrl[stp_pkg::CTRL_MGMT_MODE] ? |(int_status & int_mask)
                                    : 1'b1;
      end
   end

   // ******************************
   // checks
   // ******************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   logic [31:0] low_len;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !system_reset_n_oe_out) begin
         low_len <= 32'h0;
      end else begin
         low_len <= low_len + 32'h1;
      end
   end

   sequence s_trip_seen;
      main_power_good_in && (!cpu_a_trip_n_in || !cpu_b_trip_n_in);
   endsequence
   sequence s_regulator_off;
      ##2 regulator_enable_oe_out;
   endsequence

   a_table_strap: assert property (
      $rose(strap_done) |-> table9 == $past(regulator_table_strap_in))
      else $error("table strap not captured");
   a_addr_strap: assert property (
      $rose(strap_done) |-> addr0 == $past(addr_strap_bit0_in)
      && addr1 == $past(addr_strap_bit1_in) ##1 fan_strap_oe_out == 3'h7)
      else $error("address strap or fan takeover wrong");
   a_trip_idle: assert property (
      cpu_a_trip_n_in && cpu_b_trip_n_in && !trip_latched |=> !trip_latched)
      else $error("trip latched with inputs high");
   a_trip_disables: assert property (s_trip_seen |-> s_regulator_off)
      else $error("regulator not disabled on trip");
   a_trip_held: assert property (regulator_enable_oe_out |=> regulator_enable_oe_out [*4])
      else $error("trip latch released");
   a_fan_nopower: assert property (!main_power_good_in |=> fan_strap_out == 3'h0)
      else $error("fan output high without main power");
   a_fan_reset_high: assert property (
      $fell(rst_in) |-> fan_pwm_sixth_out && fan_pwm_seventh_out)
      else $error("fan six or seven not high after reset");
   a_reset_pulse_len: assert property (
      $fell(system_reset_n_oe_out) |-> low_len == 32'(PULSE_CYCLES))
      else $error("system reset pulse length wrong");
   a_watchdog_reload: assert property (
      !system_reset_in_n |=> watchdog_count == $past(watchdog_load))
      else $error("watchdog not held by reset input");
   a_vcode_bit5: assert property (strap_done && table9 |=> !vcode_q[5] && !vcode_q[11])
      else $error("code bit 5 visible under table 9");
   a_gpio_drive: assert property (pin_mode[0] && !pin_out[0] |=> vcode_oe_out[0])
      else $error("code pin not driven");
   a_button: assert property (ctrl[stp_pkg::CTRL_PWR_BTN] |=> power_button_oe_out)
      else $error("power button not pulled");
   a_overtemp: assert property (|sensor_overtemp_in |=> overtemp_shutdown_n_oe_out)
      else $error("overtemp not driven");
   a_mgmt_pin: assert property (
      ctrl[stp_pkg::CTRL_MGMT_MODE] && |(int_status & int_mask)
      |=> mgmt_interrupt_n_oe_out && !mgmt_interrupt_n_out)
      else $error("management interrupt not pulled low");
endmodule

// file: test/stp_board_model.sv
module stp_board_model #(
   parameter logic [2:0] STRAPS = 3'h5
) (
   // shared strap pins
   input wire logic [2:0] fan_level_in,
   input wire logic [2:0] fan_oe_in,
   output logic [2:0] strap_pin_out,
   // reset loop
   input wire logic reset_oe_in,
   input wire logic board_reset_in,
   output logic system_reset_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // strap resistors win only while the fan driver is off
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         strap_pin_out[i] = fan_oe_in[i] ? fan_level_in[i] : STRAPS[i];
      end
   end
   // board pulls reset low on its own request or during our pulse
   assign system_reset_n_out = ~(board_reset_in | reset_oe_in);
endmodule

// file: test/tb_strap_trip_reset_pin_logic.sv
`define CHK(g, e) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("Error at %0t: got %h expected %h", $time, g, e); \
   end \
end
module tb_strap_trip_reset_pin_logic;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PULSE = 20;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [2:0] strap, fan_lvl, fan_oe, sensor = 3'h0;
   logic fan6, fan7, pg = 1, trip_a_n = 1, trip_b_n = 1, chassis = 0, board_rst = 0;
   logic reg_en, reg_oe, shut, shut_oe, sys_rst_n, rst_out, rst_oe, btn, btn_oe;
   logic [11:0] vcode = 12'hFFF, vc_out, vc_oe;
   logic irq, mgmt, mgmt_oe;
   int errors = 0, comparisons = 0, n;

   always #10 clk_sys_in = ~clk_sys_in;

   stp_top #(.PULSE_CYCLES(PULSE), .TICK_CYCLES(4)) stp_top_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .addr_strap_bit0_in(strap[0]), .addr_strap_bit1_in(strap[1]),
      .regulator_table_strap_in(strap[2]), .fan_strap_out(fan_lvl),
      .fan_strap_oe_out(fan_oe), .fan_pwm_sixth_out(fan6), .fan_pwm_seventh_out(fan7),
      .main_power_good_in(pg), .cpu_a_trip_n_in(trip_a_n), .cpu_b_trip_n_in(trip_b_n),
      .sensor_overtemp_in(sensor), .chassis_intrusion_in(chassis),
      .regulator_enable_out(reg_en), .regulator_enable_oe_out(reg_oe),
      .overtemp_shutdown_n_out(shut), .overtemp_shutdown_n_oe_out(shut_oe),
      .system_reset_in_n(sys_rst_n), .system_reset_n_out(rst_out),
      .system_reset_n_oe_out(rst_oe), .power_button_out_n(btn), .power_button_oe_out(btn_oe),
      .vcode_in(vcode), .vcode_out(vc_out), .vcode_oe_out(vc_oe), .irq_out(irq),
      .mgmt_interrupt_n_out(mgmt), .mgmt_interrupt_n_oe_out(mgmt_oe));

   stp_board_model stp_board_model_i (
      .fan_level_in(fan_lvl), .fan_oe_in(fan_oe), .strap_pin_out(strap),
      .reset_oe_in(rst_oe), .board_reset_in(board_rst), .system_reset_n_out(sys_rst_n));

   // ***************
   // bus tasks
   // ***************
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      resp = bresp;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge clk_sys_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      resp = rresp;
   endtask

   task automatic close_out;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ***************
   // tests
   // ***************
   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      `CHK(fan6, 1'b1)
      `CHK(fan7, 1'b1)
      axr(stp_pkg::OFS_STATUS);
      `CHK(rd[0], 1'b1)
      `CHK(rd[2:1], 2'h1)
      axr(stp_pkg::OFS_VCODE);
      `CHK(rd, 32'h00001F1F)
      axw(stp_pkg::OFS_CTRL, 32'h000001F0);
      repeat (3) @(posedge clk_sys_in);
      `CHK(resp, 2'h0)
      `CHK(fan_lvl, 3'h7)
      pg <= 1'b0;
      trip_a_n <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      `CHK(fan_lvl, 3'h0)
      `CHK(reg_oe, 1'b0)
      trip_a_n <= 1'b1;
      pg <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      trip_b_n <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      `CHK(reg_oe, 1'b1)
      trip_b_n <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      `CHK(reg_oe, 1'b1)
      `CHK(reg_en, 1'b0)
      axw(stp_pkg::OFS_PIN_MODE, 32'h00000FFF);
      axw(stp_pkg::OFS_PIN_OUT, 32'h000000F0);
      repeat (2) @(posedge clk_sys_in);
      `CHK(vc_oe, 12'hF0F)
      `CHK(vc_out, 12'h000)
      axw(stp_pkg::OFS_CTRL, 32'h000001F2);
      repeat (2) @(posedge clk_sys_in);
      `CHK(btn_oe, 1'b1)
      `CHK(btn, 1'b0)
      axw(stp_pkg::OFS_INT_MASK, 32'h0000001F);
      sensor <= 3'h4;
      chassis <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      `CHK(shut_oe, 1'b1)
      `CHK(shut, 1'b0)
      sensor <= 3'h0;
      chassis <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      `CHK(shut_oe, 1'b0)
      axr(stp_pkg::OFS_INT_STATUS);
      `CHK(rd[4:0], 5'h16)
      `CHK(irq, 1'b1)
      axw(stp_pkg::OFS_CTRL, 32'h000001FA);
      repeat (2) @(posedge clk_sys_in);
      `CHK(mgmt_oe, 1'b1)
      `CHK(mgmt, 1'b0)
      axw(stp_pkg::OFS_INT_STATUS, 32'h0000001F);
      repeat (2) @(posedge clk_sys_in);
      `CHK(irq, 1'b0)
      `CHK(mgmt_oe, 1'b0)
      axw(stp_pkg::OFS_CTRL, 32'h000001F1);
      for (n = 0; n < 10 && rst_oe !== 1'b1; n++) @(posedge clk_sys_in);
      `CHK(rst_out, 1'b0)
      for (n = 0; n < 100 && rst_oe === 1'b1; n++) @(posedge clk_sys_in);
      `CHK(n, PULSE)
      board_rst <= 1'b1;
      axw(stp_pkg::OFS_WATCHDOG_LOAD, 32'h00000002);
      axw(stp_pkg::OFS_CTRL, 32'h000001F4);
      repeat (60) @(posedge clk_sys_in);
      `CHK(rst_oe, 1'b0)
      board_rst <= 1'b0;
      for (n = 0; n < 100 && rst_oe !== 1'b1; n++) @(posedge clk_sys_in);
      `CHK(rst_oe, 1'b1)
      axw(stp_pkg::OFS_CTRL, 32'h000001F0);
      axr(8'h40);
      `CHK(resp, 2'h2)
      close_out;
   end

   // long enough for every test several times over
   initial begin
      #400000;
      errors++;
      close_out;
   end
endmodule
